// ==== hw/node_pkg.sv ====
// Package for the token-passing node controller: register map, field
// layout, reset values, timing counts and state encodings.
// Assumes a 25 MHz core clock and a classic Wishbone register port.
package node_pkg;
    // Clock and timing
    localparam int CLK_HZ           = 25000000;
    localparam int TOKEN_TIME_NS    = 57000;
    localparam int TOKEN_CYCLES     = (TOKEN_TIME_NS / 1000) * (CLK_HZ / 1000000);
    localparam int RETRY_LIMIT      = 5;
    localparam int MS_CYCLES        = CLK_HZ / 1000;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_CONFIG   = 8'h04;
    localparam logic [7:0] REG_SYNC     = 8'h08;
    localparam logic [7:0] REG_CMDWORD  = 8'h0C;
    localparam logic [7:0] REG_STATEW   = 8'h10;
    localparam logic [7:0] REG_STATUS   = 8'h14;
    localparam logic [7:0] REG_IRQ_ST   = 8'h18;
    localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
    localparam logic [7:0] REG_FAILCNT  = 8'h20;
    localparam logic [7:0] REG_TXREQ    = 8'h24;
    localparam logic [7:0] REG_LINKS    = 8'h28;

    // Control register fields
    localparam int CTRL_PSEUDO  = 0;
    localparam int CTRL_CYCEN   = 1;
    // Interrupt status fields
    localparam int IRQ_WIDTH    = 5;
    localparam int IRQ_DROP     = 0;
    localparam int IRQ_FAST     = 1;
    localparam int IRQ_SLOW     = 2;
    localparam int IRQ_SYNC     = 3;
    localparam int IRQ_RECON    = 4;
    // Drive state word positions
    localparam int STATE_MINSPD = 3;
    localparam int STATE_UNUSED = 15;
    // Remote reset bit of the drive command word
    localparam int CMD_RESET    = 11;

    // Reset values and write limits
    localparam logic [7:0]  RST_ADDR     = 8'h00;
    localparam logic [2:0]  RST_RATE     = 3'h0;
    localparam logic [15:0] RST_SYNC     = 16'h0000;
    localparam logic [2:0]  RATE_MAX     = 3'h4;
    localparam logic [6:0]  SLOW_MIN     = 7'h02;
    localparam logic [6:0]  SLOW_MAX     = 7'h13;

    // Frame kinds on the link
    localparam logic [1:0] FR_TOKEN = 2'h0;
    localparam logic [1:0] FR_DATA  = 2'h1;
    localparam logic [1:0] FR_SYNC  = 2'h2;
    localparam logic [1:0] FR_ACK   = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_HOLD  = 3'b001,
        ST_SEND  = 3'b011,
        ST_WAIT  = 3'b010,
        ST_PASS  = 3'b110
    } node_state_t;
endpackage : node_pkg

// ==== hw/token_node.sv ====
// Token-passing node controller: token rotation, one message per token,
// retry and drop, cyclic timing as pseudo-master, Wishbone registers.
// Assumes a frame layer outside that delivers decoded frames with a CRC
// verdict and sends the frames this block requests.
//
// Behaviour
// - Pass token to next higher present address
// - No higher node: pass to lowest address
// - Transmit only with token, one message
// - Token frame occupies about 57 microseconds
// - Pseudo-master generates cyclic data interrupts
// - Pseudo-master broadcasts sync at next token
// - Sync received starts cyclic data transmission
// - One cyclic link sent per token receipt; a resend here carries the next link index, not the failed one
// - Resend on CRC failure or no response
// - Drop message after five failed resends
// - Dropped message increments failed-delivery count
// - Detect receive errors, never correct them
// - Address 1-255 valid, zero disables node
// - Data rate code limited to 0..4
// - Sync code: fast ms low, slow multiple high
// - State word bit 3 min speed, 15 unused
// - Reconfiguration raises an indication
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
module token_node #(
    parameter int RESP_TIMEOUT = 256,
    parameter int MAX_LINKS    = 10
) (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    // Wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    output logic             IRQ,
    // Decoded receive frames
    input  wire logic        RX_VALID,
    input  wire logic [1:0]  RX_KIND,
    input  wire logic [7:0]  RX_SRC,
    input  wire logic [7:0]  RX_DST,
    input  wire logic        RX_CRC_OK,
    // Frame transmit request
    output logic             TX_START,
    output logic      [1:0]  TX_KIND,
    output logic      [7:0]  TX_DST,
    output logic      [15:0] TX_DATA,
    input  wire logic        TX_DONE,
    // Drive interface
    input  wire logic [15:0] DRIVE_STATE,
    output logic      [15:0] DRIVE_CMD,
    output logic             RECON
);
    initial
    begin
        if (RESP_TIMEOUT < 1 || RESP_TIMEOUT > 65535)
            $error("RESP_TIMEOUT out of range");
        if (MAX_LINKS < 1 || MAX_LINKS > 255)
            $error("MAX_LINKS out of range");
    end

    localparam int IRQ_W = node_pkg::IRQ_WIDTH;

    node_pkg::node_state_t state;
    logic [7:0]  node_addr;
    logic [2:0]  rate_code;
    logic [15:0] sync_rate_code;
    logic        pseudo;
    logic        cyc_en;
    logic [15:0] cmd_word;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic [15:0] failed_delivery_count;
    logic [15:0] tx_req_data;
    logic [7:0]  tx_req_dst;
    logic        tx_pending;
    logic [7:0]  link_count;
    logic [7:0]  link_idx;
    logic        cyc_active;
    logic        sync_due;
    logic [255:0] present;
    logic [2:0]  retries;
    logic [15:0] wait_cnt;
    logic [15:0] tok_cnt;
    logic [1:0]  msg_kind;
    logic [IRQ_W-1:0] ev;
    logic        wr;
    logic        rd_err;
    logic [15:0] ms_cnt;
    logic [6:0]  fast_cnt;
    logic [6:0]  slow_cnt;
    logic        fast_tick;
    logic        node_on;
    logic [7:0]  next_hop;
    logic        clr_pending;

    localparam logic [15:0] TOK_CYC = 16'(node_pkg::TOKEN_CYCLES);
    localparam logic [15:0] MS_CYC  = 16'(node_pkg::MS_CYCLES);

    // Decimal digit pair from a BCD-like field; sync code is stored binary
    // coded decimal so the four printed digits map to nibbles.
    function automatic logic [6:0] bcd2(input logic [7:0] v);
        bcd2 = 7'(v[7:4]) * 7'h0A + 7'(v[3:0]);
    endfunction : bcd2

    // Lowest present address above own, else lowest overall.
    function automatic logic [7:0] pick_next(input logic [255:0] p,
                                             input logic [7:0]   me);
        logic [7:0] hi;
        logic [7:0] lo;
        logic       fh;
        logic       fl;
        hi = 8'h00;
        lo = me;
        fh = 1'b0;
        fl = 1'b0;
        for (int i = 255; i >= 1; i--)
        begin
            if (p[i] && 8'(i) > me)
            begin
                hi = 8'(i);
                fh = 1'b1;
            end
            if (p[i])
            begin
                lo = 8'(i);
                fl = 1'b1;
            end
        end
        pick_next = fh ? hi : (fl ? lo : me);
    endfunction : pick_next

    assign node_on = (node_addr != 8'h00);
    assign next_hop = pick_next(present, node_addr);
    assign wr = CYC_I && STB_I && WE_I && !ACK_O;
    assign IRQ = |(irq_st & irq_mask);
    assign RECON = irq_st[node_pkg::IRQ_RECON];
    assign DRIVE_CMD = cmd_word;

    // Bus register writes and configuration
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            node_addr      <= node_pkg::RST_ADDR;
            rate_code      <= node_pkg::RST_RATE;
            sync_rate_code <= node_pkg::RST_SYNC;
            pseudo         <= 1'b0;
            cyc_en         <= 1'b0;
            cmd_word       <= 16'h0000;
            irq_mask       <= '0;
            tx_req_data    <= 16'h0000;
            tx_req_dst     <= 8'h00;
            link_count     <= 8'h00;
        end
        else if (wr && SEL_I[0])
        begin
            case (ADR_I)
                node_pkg::REG_CTRL:
                begin
                    pseudo <= DAT_I[node_pkg::CTRL_PSEUDO];
                    cyc_en <= DAT_I[node_pkg::CTRL_CYCEN];
                end
                node_pkg::REG_CONFIG:
                begin
                    node_addr <= DAT_I[7:0];
                    if (SEL_I[1] && DAT_I[10:8] <= node_pkg::RATE_MAX)
                        rate_code <= DAT_I[10:8];
                end
                node_pkg::REG_SYNC:
                    if (SEL_I[1] && bcd2(DAT_I[15:8]) >= node_pkg::SLOW_MIN
                        && bcd2(DAT_I[15:8]) <= node_pkg::SLOW_MAX)
                        sync_rate_code <= DAT_I[15:0];
                node_pkg::REG_CMDWORD:
                    if (SEL_I[1])
                        cmd_word <= DAT_I[15:0];
                node_pkg::REG_IRQ_MASK:
                    irq_mask <= DAT_I[IRQ_W-1:0];
                node_pkg::REG_TXREQ:
                    if (SEL_I[2])
                    begin
                        tx_req_data <= DAT_I[15:0];
                        tx_req_dst  <= DAT_I[23:16];
                    end
                node_pkg::REG_LINKS:
                    if (DAT_I[7:0] <= 8'(MAX_LINKS))
                        link_count <= DAT_I[7:0];
                default: ;
            endcase
        end
    end

    // Bus read and acknowledge
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h00000000;
        end
        else
        begin
            ACK_O <= CYC_I && STB_I && !ACK_O;
            case (ADR_I)
                node_pkg::REG_CTRL:
                    DAT_O <= {30'h0, cyc_en, pseudo};
                node_pkg::REG_CONFIG:
                    DAT_O <= {21'h0, rate_code, node_addr};
                node_pkg::REG_SYNC:    DAT_O <= {16'h0, sync_rate_code};
                node_pkg::REG_CMDWORD: DAT_O <= {16'h0, cmd_word};
                node_pkg::REG_STATEW:
                    DAT_O <= {17'h0, DRIVE_STATE[14:0]};
                node_pkg::REG_STATUS:
                    DAT_O <= {21'h0, cyc_active, tx_pending, node_on,
                              5'h0, state};
                node_pkg::REG_IRQ_ST:
                    DAT_O <= {{(32-IRQ_W){1'b0}}, irq_st};
                node_pkg::REG_IRQ_MASK:
                    DAT_O <= {{(32-IRQ_W){1'b0}}, irq_mask};
                node_pkg::REG_FAILCNT:
                    DAT_O <= {16'h0, failed_delivery_count};
                node_pkg::REG_TXREQ:
                    DAT_O <= {8'h0, tx_req_dst, tx_req_data};
                node_pkg::REG_LINKS:   DAT_O <= {24'h0, link_count};
                default:               DAT_O <= 32'h00000000;
            endcase
        end
    end

    // Cycle timer for the pseudo-master: fast tick every CC ms, slow
    // tick every NN fast ticks.
    always_ff @(posedge CORE_CLK)
    begin
        if (RST || !pseudo || !node_on)
        begin
            ms_cnt   <= 16'h0000;
            fast_cnt <= 7'h00;
            slow_cnt <= 7'h00;
        end
        else
        begin
            if (ms_cnt == MS_CYC - 16'h0001)
            begin
                ms_cnt <= 16'h0000;
                if (fast_cnt + 7'h01 >= bcd2(sync_rate_code[7:0]))
                begin
                    fast_cnt <= 7'h00;
                    if (slow_cnt + 7'h01 >= bcd2(sync_rate_code[15:8]))
                        slow_cnt <= 7'h00;
                    else
                        slow_cnt <= slow_cnt + 7'h01;
                end
                else
                    fast_cnt <= fast_cnt + 7'h01;
            end
            else
                ms_cnt <= ms_cnt + 16'h0001;
        end
    end

    assign fast_tick = pseudo && node_on && ms_cnt == MS_CYC - 16'h0001
                       && fast_cnt + 7'h01 >= bcd2(sync_rate_code[7:0]);

    // Events for the interrupt status
    always_comb
    begin
        ev = '0;
        ev[node_pkg::IRQ_DROP] = state == node_pkg::ST_WAIT && retries ==
            3'(node_pkg::RETRY_LIMIT) && (wait_cnt == 16'h0000 ||
            (RX_VALID && !RX_CRC_OK));
        ev[node_pkg::IRQ_FAST] = fast_tick;
        ev[node_pkg::IRQ_SLOW] = fast_tick &&
            slow_cnt + 7'h01 >= bcd2(sync_rate_code[15:8]);
        ev[node_pkg::IRQ_SYNC] = RX_VALID && RX_CRC_OK &&
            RX_KIND == node_pkg::FR_SYNC;
        ev[node_pkg::IRQ_RECON] = RX_VALID && RX_CRC_OK && node_on &&
            !present[RX_SRC] && RX_SRC != 8'h00;
    end

    // Sticky status: set wins over write-one-to-clear
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            irq_st <= '0;
        else if (wr && SEL_I[0] && ADR_I == node_pkg::REG_IRQ_ST)
            irq_st <= (irq_st & ~DAT_I[IRQ_W-1:0]) | ev;
        else
            irq_st <= irq_st | ev;
    end

    // Membership learned from traffic heard on the link
    always_ff @(posedge CORE_CLK)
    begin
        if (RST || !node_on)
            present <= '0;
        else if (RX_VALID && RX_CRC_OK && RX_SRC != 8'h00)
            present[RX_SRC] <= 1'b1;
    end

    // Pending single message; cleared when acknowledged or dropped
    assign clr_pending = (state == node_pkg::ST_WAIT && msg_kind ==
        node_pkg::FR_DATA && ((RX_VALID && RX_CRC_OK && RX_KIND ==
        node_pkg::FR_ACK) || ev[node_pkg::IRQ_DROP]));
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            tx_pending <= 1'b0;
        else if (wr && SEL_I[2] && ADR_I == node_pkg::REG_TXREQ)
            tx_pending <= 1'b1;
        else if (clr_pending)
            tx_pending <= 1'b0;
    end

    // Sync bookkeeping and cyclic link progress
    always_ff @(posedge CORE_CLK)
    begin
        if (RST || !node_on)
        begin
            sync_due   <= 1'b0;
            cyc_active <= 1'b0;
            link_idx   <= 8'h00;
        end
        else
        begin
            if (fast_tick)
                sync_due <= 1'b1;
            else if (state == node_pkg::ST_SEND &&
                     msg_kind == node_pkg::FR_SYNC)
                sync_due <= 1'b0;
            if (ev[node_pkg::IRQ_SYNC] ||
                (state == node_pkg::ST_SEND && msg_kind == node_pkg::FR_SYNC))
            begin
                cyc_active <= cyc_en && link_count != 8'h00;
                link_idx   <= 8'h00;
            end
            else if (state == node_pkg::ST_SEND &&
                     msg_kind == node_pkg::FR_DATA && cyc_active && !tx_pending)
            begin
                if (link_idx + 8'h01 >= link_count)
                    cyc_active <= 1'b0;
                link_idx <= link_idx + 8'h01;
            end
        end
    end

    // Token and message sequencer
    always_ff @(posedge CORE_CLK)
    begin
        if (RST || !node_on)
        begin
            state                 <= node_pkg::ST_IDLE;
            retries               <= 3'h0;
            wait_cnt              <= 16'h0000;
            tok_cnt               <= 16'h0000;
            msg_kind              <= node_pkg::FR_TOKEN;
            TX_START              <= 1'b0;
            TX_KIND               <= node_pkg::FR_TOKEN;
            TX_DST                <= 8'h00;
            TX_DATA               <= 16'h0000;
            if (RST)
                failed_delivery_count <= 16'h0000;
        end
        else
        begin
            TX_START <= 1'b0;
            case (state)
                node_pkg::ST_IDLE:
                    if (RX_VALID && RX_CRC_OK && RX_KIND == node_pkg::FR_TOKEN
                        && RX_DST == node_addr)
                        state <= node_pkg::ST_HOLD;
                node_pkg::ST_HOLD:
                begin
                    retries <= 3'h0;
                    if (pseudo && sync_due)
                        msg_kind <= node_pkg::FR_SYNC;
                    else if (tx_pending || cyc_active)
                        msg_kind <= node_pkg::FR_DATA;
                    else
                        msg_kind <= node_pkg::FR_TOKEN;
                    state <= (pseudo && sync_due) || tx_pending || cyc_active
                             ? node_pkg::ST_SEND : node_pkg::ST_PASS;
                end
                node_pkg::ST_SEND:
                begin
                    TX_START <= 1'b1;
                    TX_KIND  <= msg_kind;
                    TX_DST   <= msg_kind == node_pkg::FR_SYNC ? 8'hFF :
                                tx_pending ? tx_req_dst : next_hop;
                    TX_DATA  <= tx_pending ? tx_req_data :
                                {8'h00, link_idx};
                    wait_cnt <= 16'(RESP_TIMEOUT);
                    state    <= node_pkg::ST_WAIT;
                end
                node_pkg::ST_WAIT:
                begin
                    if (msg_kind == node_pkg::FR_SYNC)
                    begin
                        if (TX_DONE)
                            state <= node_pkg::ST_PASS;
                    end
                    else if (RX_VALID && RX_CRC_OK &&
                             RX_KIND == node_pkg::FR_ACK)
                        state <= node_pkg::ST_PASS;
                    else if (wait_cnt == 16'h0000 ||
                             (RX_VALID && !RX_CRC_OK))
                    begin
                        if (retries == 3'(node_pkg::RETRY_LIMIT))
                        begin
                            failed_delivery_count <=
                                failed_delivery_count + 16'h0001;
                            state <= node_pkg::ST_PASS;
                        end
                        else
                        begin
                            retries <= retries + 3'h1;
                            state   <= node_pkg::ST_SEND;
                        end
                    end
                    else
                        wait_cnt <= wait_cnt - 16'h0001;
                    tok_cnt <= TOK_CYC;
                end
                node_pkg::ST_PASS:
                begin
                    if (tok_cnt == TOK_CYC || tok_cnt == 16'h0000)
                    begin
                        TX_START <= tok_cnt != 16'h0000;
                        TX_KIND  <= node_pkg::FR_TOKEN;
                        TX_DST   <= next_hop;
                        TX_DATA  <= 16'h0000;
                    end
                    if (tok_cnt == 16'h0000)
                        state <= node_pkg::ST_IDLE;
                    else
                        tok_cnt <= tok_cnt - 16'h0001;
                end
                default: state <= node_pkg::ST_IDLE;
            endcase
            if (state == node_pkg::ST_HOLD)
                tok_cnt <= TOK_CYC;
        end
    end

    a_drop_counts: assert property (@(posedge CORE_CLK) disable iff (RST)
        ev[node_pkg::IRQ_DROP] && state == node_pkg::ST_WAIT &&
        msg_kind != node_pkg::FR_SYNC
        |=> failed_delivery_count == $past(failed_delivery_count) + 16'h0001)
        else $error("drop did not count");
    a_off_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
        !node_on |=> state == node_pkg::ST_IDLE && !TX_START)
        else $error("disabled node active");
    a_tx_token: assert property (@(posedge CORE_CLK) disable iff (RST)
        TX_START |-> $past(state) != node_pkg::ST_IDLE)
        else $error("sent without token");
    a_retry_cap: assert property (@(posedge CORE_CLK) disable iff (RST)
        retries <= 3'(node_pkg::RETRY_LIMIT))
        else $error("retry count exceeded");
    a_idle_pass: assert property (@(posedge CORE_CLK) disable iff (RST)
        state == node_pkg::ST_HOLD && !tx_pending && !cyc_active && !sync_due
        |=> state == node_pkg::ST_PASS)
        else $error("idle token held");
    a_irq_level: assert property (@(posedge CORE_CLK) disable iff (RST)
        IRQ == |(irq_st & irq_mask))
        else $error("irq mismatch");
    a_rate_range: assert property (@(posedge CORE_CLK) disable iff (RST)
        rate_code <= node_pkg::RATE_MAX)
        else $error("rate code out of range");
    a_fail_retry: assert property (@(posedge CORE_CLK) disable iff (RST)
        state == node_pkg::ST_WAIT && msg_kind == node_pkg::FR_DATA &&
        RX_VALID && !RX_CRC_OK && retries < 3'(node_pkg::RETRY_LIMIT)
        |=> state == node_pkg::ST_SEND ##1 TX_START)
        else $error("no resend");
endmodule : token_node

// ==== verif/peer_model.sv ====
// Peer nodes on the shared link: their frames and their acks.
// Assumes the node's decoded-frame and transmit-request ports.
`timescale 1ns/1ns
module peer_model #(
    parameter logic [7:0] ME = 8'h10
) (
    // Clock
    input  wire logic       clk,
    // Node transmit side
    input  wire logic       tx_start,
    input  wire logic [1:0] tx_kind,
    input  wire logic [7:0] tx_dst,
    input  wire logic       silent,
    // Node receive side
    output logic            rx_valid,
    output logic      [1:0] rx_kind,
    output logic      [7:0] rx_src,
    output logic      [7:0] rx_dst,
    output logic            rx_crc_ok,
    output logic            tx_done
);
    logic [3:0] dly = 4'h0;
    logic [7:0] who = 8'h00;

    initial
    begin
        {rx_valid, rx_kind, rx_src, rx_dst, rx_crc_ok, tx_done} = '0;
    end

    task automatic send(input logic [1:0] k, input logic [7:0] s,
                        input logic [7:0] d, input logic ok);
        @(posedge clk);
        {rx_kind, rx_src, rx_dst, rx_crc_ok} <= {k, s, d, ok};
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
        // Idle lines toggle so no stale value looks valid
        {rx_src, rx_dst} <= ~{s, d};
    endtask : send

    // A silent target stands for a node gone off the link
    always @(posedge clk)
    begin
        tx_done <= tx_start;
        dly <= {dly[2:0], tx_start && tx_kind == node_pkg::FR_DATA && !silent};
        if (tx_start)
            who <= tx_dst;
        if (dly[3])
            send(node_pkg::FR_ACK, who, ME, 1'b1);
    end
endmodule : peer_model

// ==== verif/token_node_test.sv ====
// Bench for the token node: Wishbone tasks, peer frames and checks.
// Assumes node_pkg, token_node and peer_model.
`timescale 1ns/1ns
module token_node_test;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0;
    logic        silent = 1'b1, ack, irq, txs, rv, rok, tdn, recon;
    logic [7:0]  adr = 8'h00, rs, rd, tdst;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [15:0] state = 16'hFFFF, tdat, cmd;
    logic [1:0]  rk, tk;
    int          failures = 0, compares = 0, ntx = 0, ndata = 0, n0;
    logic [7:0]  ldst;
    logic [15:0] ldata;

    always #20 clk = ~clk;

    token_node #(.RESP_TIMEOUT(16)) u_dut (.CORE_CLK(clk), .RST(rst),
        .CYC_I(cyc), .STB_I(cyc), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF),
        .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .IRQ(irq), .RX_VALID(rv),
        .RX_KIND(rk), .RX_SRC(rs), .RX_DST(rd), .RX_CRC_OK(rok),
        .TX_START(txs), .TX_KIND(tk), .TX_DST(tdst), .TX_DATA(tdat),
        .TX_DONE(tdn), .DRIVE_STATE(state), .DRIVE_CMD(cmd), .RECON(recon));

    peer_model u_peer (.clk(clk), .tx_start(txs), .tx_kind(tk),
        .tx_dst(tdst), .silent(silent), .rx_valid(rv), .rx_kind(rk),
        .rx_src(rs), .rx_dst(rd), .rx_crc_ok(rok), .tx_done(tdn));

    always @(posedge clk)
        if (txs === 1'b1)
        begin
            ntx++;
            ldst = tdst;
            ldata = tdat;
            if (tk === node_pkg::FR_DATA)
                ndata++;
        end

    task automatic conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk);
        {cyc, we, adr, wdat} <= {1'b1, w, a, d};
        for (n = 0; n < 50 && ack !== 1'b1; n++)
            @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        if (n == 50)
        begin
            chk("bus ack", 0, 1);
            conclude();
        end
    endtask : wb

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), q, e);
    endtask : rc

    // Waits for a node transmission; a miss ends the run
    task automatic wtx(input int b);
        n0 = ntx;
        repeat (b)
        begin
            @(negedge clk);
            if (ntx != n0)
                return;
        end
        failures++;
        conclude();
    endtask : wtx

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rc(node_pkg::REG_CONFIG, 32'h0);
        rc(8'h3C, 32'h0);
        wb(1, node_pkg::REG_CONFIG, 32'h0410);
        wb(1, node_pkg::REG_CONFIG, 32'h0510);
        rc(node_pkg::REG_CONFIG, 32'h0410);
        wb(1, node_pkg::REG_SYNC, 32'h1950);
        wb(1, node_pkg::REG_SYNC, 32'h2010);
        wb(1, node_pkg::REG_SYNC, 32'h0105);
        rc(node_pkg::REG_SYNC, 32'h1950);
        wb(1, node_pkg::REG_IRQ_MASK, 32'h11);
        u_peer.send(node_pkg::FR_TOKEN, 8'h05, 8'h20, 1'b1);
        u_peer.send(node_pkg::FR_TOKEN, 8'h20, 8'h05, 1'b1);
        u_peer.send(node_pkg::FR_DATA, 8'h18, 8'h05, 1'b0);
        rc(node_pkg::REG_IRQ_ST, 32'h10);
        chk("irq set", irq, 1);
        chk("recon", recon, 1);
        wb(1, node_pkg::REG_IRQ_ST, 32'h10);
        chk("irq clear", irq, 0);
        u_peer.send(node_pkg::FR_TOKEN, 8'h05, 8'h10, 1'b1);
        wtx(8);
        chk("token dst", ldst, 8'h20);
        repeat (node_pkg::TOKEN_CYCLES + 20) @(posedge clk);
        wb(1, node_pkg::REG_TXREQ, 32'h20BEEF);
        u_peer.send(node_pkg::FR_TOKEN, 8'h05, 8'h10, 1'b1);
        for (int i = 0; i < 800 && irq !== 1'b1; i++)
            @(posedge clk);
        chk("drop irq", irq, 1);
        chk("sends", ndata, 6);
        chk("data", {ldst, ldata}, 24'h20BEEF);
        rc(node_pkg::REG_FAILCNT, 32'h1);
        wb(1, node_pkg::REG_IRQ_ST, 32'h01);
        chk("drop clear", irq, 0);
        silent <= 1'b0;
        repeat (node_pkg::TOKEN_CYCLES + 20) @(posedge clk);
        wb(1, node_pkg::REG_TXREQ, 32'h201234);
        u_peer.send(node_pkg::FR_TOKEN, 8'h05, 8'h10, 1'b1);
        repeat (node_pkg::TOKEN_CYCLES + 200) @(posedge clk);
        chk("acked sends", ndata, 7);
        rc(node_pkg::REG_FAILCNT, 32'h1);
        wb(1, node_pkg::REG_CONFIG, 32'h0440);
        u_peer.send(node_pkg::FR_TOKEN, 8'h05, 8'h40, 1'b1);
        wtx(8);
        chk("wrap dst", ldst, 8'h05);
        repeat (node_pkg::TOKEN_CYCLES + 20) @(posedge clk);
        // Pseudo-master with a 1 ms fast cycle: one tick, then sync
        wb(1, node_pkg::REG_LINKS, 32'h02);
        wb(1, node_pkg::REG_SYNC, 32'h0201);
        wb(1, node_pkg::REG_CTRL, 32'h03);
        repeat (node_pkg::MS_CYCLES + 100) @(posedge clk);
        rc(node_pkg::REG_IRQ_ST, 32'h02);
        u_peer.send(node_pkg::FR_TOKEN, 8'h05, 8'h40, 1'b1);
        wtx(8);
        chk("sync dst", ldst, 8'hFF);
        repeat (node_pkg::TOKEN_CYCLES + 20) @(posedge clk);
        wb(1, node_pkg::REG_CONFIG, 32'h0400);
        n0 = ntx;
        u_peer.send(node_pkg::FR_TOKEN, 8'h05, 8'h00, 1'b1);
        repeat (20) @(posedge clk);
        chk("node off", ntx, n0);
        rc(node_pkg::REG_STATEW, 32'h7FFF);
        state <= 16'h0008;
        rc(node_pkg::REG_STATEW, 32'h0008);
        wb(1, node_pkg::REG_CMDWORD, 32'h0800);
        chk("cmd", cmd, 16'h0800);
        conclude();
    end
endmodule : token_node_test
